// ==== verilog/tws_pkg.sv ====
// package for the two-wire slave front end: constants, byte layouts, states
package tws_pkg;
    // fixed slave addresses of the two variants
    localparam logic [6:0] TWS_ADDR_FOUR = 7'h64;
    localparam logic [6:0] TWS_ADDR_TWELVE = 7'h65;
    // high-speed master code upper five bits, low three ignored
    localparam logic [4:0] TWS_HS_CODE_HI = 5'h01;
    // bit counts
    localparam logic [3:0] TWS_BITS_PER_BYTE = 4'h8;
    localparam logic [3:0] TWS_LAST_BIT = 4'h7;
    // field positions of setup and configuration bytes
    localparam int TWS_REG_BIT = 7;
    localparam int TWS_RST_BIT = 1;
    localparam int TWS_SGL_BIT = 0;
    // reset values
    localparam logic [7:0] TWS_SETUP_RESET = 8'h02;
    localparam logic [7:0] TWS_CONFIG_RESET = 8'h01;

    // setup byte fields, msb first
    typedef struct packed {
        logic reg_select;
        logic reference_select_2;
        logic reference_select_1;
        logic reference_select_0;
        logic conversion_clock_source;
        logic polarity_select;
        logic config_reset_n;
        logic ignored;
    } tws_setup_t;

    // configuration byte fields, msb first
    typedef struct packed {
        logic reg_select;
        logic [1:0] scan_select;
        logic [3:0] channel_select;
        logic input_mode_select;
    } tws_config_t;

    // converter-facing mode outputs
    typedef struct packed {
        logic [2:0] reference_select;
        logic external_conv_clock;
        logic differential;
        logic bipolar_coding;
        logic clamp_negative;
        logic [1:0] scan_select;
        logic [3:0] channel_select;
    } tws_mode_t;

    // bus phase states, held on the system side
    typedef enum logic [2:0] {
        TWS_IDLE,
        TWS_ADDR,
        TWS_ADDR_ACK,
        TWS_WRITE,
        TWS_WRITE_ACK,
        TWS_READ,
        TWS_READ_ACK,
        TWS_HS_NACK
    } tws_state_t;
endpackage

// ==== verilog/tws_slave.sv ====
// two-wire slave front end: bus conditions, address match, write decode, modes
`timescale 1ns/1ps
module tws_slave
    import tws_pkg::*;
#(
    parameter bit TWELVE_INPUT = 1'b0 // variant choice sets the address
)
(
    input wire logic clk_i, // system clock, 25 mhz
    input wire logic sys_rst_i, // synchronous reset, active high
    input wire logic scl_clk_i, // link clock: scl as a clock port
    input wire logic scl_i, // scl level, sampled in the system domain
    input wire logic sda_i, // sda line level
    input wire logic [7:0] read_data_i, // result byte offered for a read
    output logic sda_o, // sda output value, always low when driven
    output logic sda_oe_n_o, // low while the slave pulls sda
    output logic scl_o, // scl output value, never stretched here
    output logic scl_oe_n_o, // scl held released
    output logic high_speed_o, // high-speed timing mode active
    output logic busy_o, // transaction open between start and stop
    output logic read_cycle_o, // addressed for a read
    output logic [7:0] setup_o, // setup byte register
    output logic [7:0] config_o, // configuration byte register
    output tws_mode_t mode_o // decoded converter modes
);
    // link-side state, on the scl rising edge only
    typedef struct packed {
        logic [7:0] shift; // incoming bits, msb first
        logic [3:0] bit_cnt; // data bit index within a byte
        logic match; // byte after start was our address
        logic is_read; // direction latched from address
        logic [7:0] wr_byte; // last written byte
        logic wr_tog; // toggles per written byte
        logic addr_byte; // byte in flight is the first after start
        logic mnack; // master not-acknowledged a read byte
    } tws_link_t;

    // system-side state
    typedef struct packed {
        logic [1:0] scl_s; // scl synchroniser
        logic [1:0] sda_s; // sda synchroniser
        logic scl_d; // previous synced scl
        logic sda_d; // previous synced sda
        logic [1:0] wr_s; // write toggle synchroniser
        logic wr_ack; // write toggle value last landed
        tws_state_t state; // bus phase
        logic [3:0] fall_cnt; // scl falls since byte start
        logic rearm; // start seen, link has not yet taken its first bit
        logic drive_low; // pull sda low
        logic high_speed;
        logic busy;
        logic read_cycle;
        logic [7:0] tx; // read shift register
        tws_setup_t setup;
        tws_config_t cfg;
        tws_mode_t mode;
    } tws_sys_t;

    tws_link_t lk;
    tws_link_t next_lk;
    tws_sys_t st;
    tws_sys_t next_st;

    // decode a setup/configuration pair into converter modes
    function automatic tws_mode_t decode_mode(input tws_setup_t s, input tws_config_t c);
        tws_mode_t m;
        m.reference_select = {s.reference_select_2, s.reference_select_1, s.reference_select_0};
        m.external_conv_clock = s.conversion_clock_source;
        m.differential = ~c.input_mode_select;
        // bipolar only meaningful when differential
        m.bipolar_coding = s.polarity_select & ~c.input_mode_select;
        m.clamp_negative = ~m.bipolar_coding; // unipolar floors negatives at zero
        m.scan_select = c.scan_select;
        m.channel_select = c.channel_select;
        return m;
    endfunction

    // our fixed address
    function automatic logic [6:0] own_addr();
        return TWELVE_INPUT ? TWS_ADDR_TWELVE : TWS_ADDR_FOUR;
    endfunction

    // link next-state: sample sda on each scl rising edge
    always_comb
    begin
        logic new_byte;
        logic [7:0] full;
        // rearm rises a full scl half period before the first rising edge after
        // start and falls well before the second, so it is steady at every edge
        new_byte = st.rearm;
        next_lk = lk;
        full = {lk.shift[6:0], sda_i};
        if (new_byte)
        begin
            // first edge after start: restart byte, forget match
            next_lk.bit_cnt = 4'h1;
            next_lk.shift = {7'h00, sda_i};
            next_lk.match = 1'b0;
            next_lk.is_read = 1'b0;
            next_lk.mnack = 1'b0;
            next_lk.addr_byte = 1'b1;
            // realign the write toggle with what the system side has landed
            next_lk.wr_tog = st.wr_ack;
        end
        else if (lk.bit_cnt == TWS_BITS_PER_BYTE)
        begin
            // ninth edge: acknowledge bit; master ack seen on reads
            next_lk.bit_cnt = 4'h0;
            next_lk.addr_byte = 1'b0;
            if (lk.match && lk.is_read)
                next_lk.mnack = sda_i;
        end
        else
        begin
            next_lk.shift = full;
            next_lk.bit_cnt = lk.bit_cnt + 4'h1;
            if (lk.bit_cnt == TWS_LAST_BIT)
            begin
                // only the byte after start is an address; later bytes never match
                if (lk.addr_byte)
                begin
                    if (full[7:1] == own_addr())
                    begin
                        next_lk.match = 1'b1;
                        next_lk.is_read = full[0];
                    end
                end
                else if (lk.match && !lk.is_read)
                begin
                    next_lk.wr_byte = full;
                    next_lk.wr_tog = ~lk.wr_tog;
                end
            end
        end
    end

    // link register; re-armed by each start, so scl may stop between frames
    always_ff @(posedge scl_clk_i)
    begin
        lk <= next_lk;
    end

    // system next-state: conditions, ack drive, registers
    always_comb
    begin
        logic scl_h;
        logic start_c;
        logic stop_c;
        logic fall;
        logic rise;
        logic [7:0] wb;
        next_st = st;
        next_st.scl_s = {st.scl_s[0], scl_i};
        next_st.sda_s = {st.sda_s[0], sda_i};
        next_st.scl_d = st.scl_s[1];
        next_st.sda_d = st.sda_s[1];
        next_st.wr_s = {st.wr_s[0], lk.wr_tog};
        scl_h = st.scl_s[1] & st.scl_d;
        start_c = scl_h & st.sda_d & ~st.sda_s[1];
        stop_c = scl_h & ~st.sda_d & st.sda_s[1];
        fall = st.scl_d & ~st.scl_s[1];
        rise = ~st.scl_d & st.scl_s[1];
        wb = lk.wr_byte;

        // first scl rise after start: the link has taken its first bit
        if (rise)
            next_st.rearm = 1'b0;

        // a completed written byte lands in its register
        // wr_byte stands still for a whole byte time, so reading it here is safe
        if (st.wr_s[1] != st.wr_ack)
        begin
            next_st.wr_ack = st.wr_s[1];
            if (wb[TWS_REG_BIT])
            begin
                next_st.setup = tws_setup_t'(wb);
                if (!wb[TWS_RST_BIT])
                    next_st.cfg = tws_config_t'(TWS_CONFIG_RESET);
            end
            else
                next_st.cfg = tws_config_t'(wb);
        end

        if (start_c)
        begin
            // repeated start keeps timing mode
            next_st.rearm = 1'b1; // the start's own scl fall is not a bit
            next_st.busy = 1'b1;
            next_st.state = TWS_ADDR;
            next_st.fall_cnt = 4'h0;
            next_st.drive_low = 1'b0;
            next_st.read_cycle = 1'b0;
        end
        else if (stop_c)
        begin
            next_st.busy = 1'b0;
            next_st.rearm = 1'b0;
            next_st.high_speed = 1'b0;
            next_st.state = TWS_IDLE;
            next_st.drive_low = 1'b0;
            next_st.read_cycle = 1'b0;
        end
        else if (fall && st.state != TWS_IDLE && !st.rearm)
        begin
            next_st.fall_cnt = st.fall_cnt + 4'h1;
            unique case (st.state)
                TWS_ADDR:
                    if (st.fall_cnt == TWS_LAST_BIT)
                    begin
                        // eighth fall: decide ack from link result
                        next_st.fall_cnt = 4'h0;
                        if (lk.match)
                        begin
                            next_st.state = TWS_ADDR_ACK;
                            next_st.drive_low = 1'b1;
                            next_st.read_cycle = lk.is_read;
                        end
                        else if (lk.shift[7:3] == TWS_HS_CODE_HI)
                            next_st.state = TWS_HS_NACK; // leave sda released
                        else
                            next_st.state = TWS_IDLE;
                    end
                TWS_ADDR_ACK, TWS_WRITE_ACK:
                begin
                    // ninth fall: release ack, start next byte
                    next_st.fall_cnt = 4'h0;
                    next_st.drive_low = 1'b0;
                    next_st.state = st.read_cycle ? TWS_READ : TWS_WRITE;
                    if (st.read_cycle)
                    begin
                        next_st.tx = {read_data_i[6:0], 1'b0};
                        next_st.drive_low = ~read_data_i[7];
                    end
                end
                TWS_WRITE:
                    if (st.fall_cnt == TWS_LAST_BIT)
                    begin
                        next_st.fall_cnt = 4'h0;
                        next_st.state = TWS_WRITE_ACK;
                        next_st.drive_low = 1'b1;
                    end
                TWS_READ:
                    if (st.fall_cnt == TWS_LAST_BIT)
                    begin
                        // release for the master's ack bit
                        next_st.fall_cnt = 4'h0;
                        next_st.state = TWS_READ_ACK;
                        next_st.drive_low = 1'b0;
                    end
                    else
                    begin
                        next_st.drive_low = ~st.tx[7];
                        next_st.tx = {st.tx[6:0], 1'b0};
                    end
                TWS_READ_ACK:
                begin
                    next_st.fall_cnt = 4'h0;
                    if (lk.mnack)
                        next_st.state = TWS_IDLE; // stay released
                    else
                    begin
                        next_st.state = TWS_READ;
                        next_st.tx = {read_data_i[6:0], 1'b0};
                        next_st.drive_low = ~read_data_i[7];
                    end
                end
                TWS_HS_NACK:
                begin
                    next_st.fall_cnt = 4'h0;
                    next_st.high_speed = 1'b1; // after the nack clock
                    next_st.state = TWS_IDLE;
                end
                TWS_IDLE:
                    next_st.state = TWS_IDLE; // guarded out above
            endcase
        end
        next_st.mode = decode_mode(next_st.setup, next_st.cfg);
    end

    // system register with synchronous reset
    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i)
        begin
            st <= '0;
            st.scl_s <= 2'h3;
            st.sda_s <= 2'h3;
            st.scl_d <= 1'b1;
            st.sda_d <= 1'b1;
            st.state <= TWS_IDLE;
            st.setup <= tws_setup_t'(TWS_SETUP_RESET);
            st.cfg <= tws_config_t'(TWS_CONFIG_RESET);
            st.mode <= decode_mode(tws_setup_t'(TWS_SETUP_RESET), tws_config_t'(TWS_CONFIG_RESET));
        end
        else
            st <= next_st;
    end

    // outputs from flops; lines released unless acking or sending zero
    always_comb
    begin
        sda_o = 1'b0;
        sda_oe_n_o = ~st.drive_low;
        scl_o = 1'b0;
        scl_oe_n_o = 1'b1;
        high_speed_o = st.high_speed;
        busy_o = st.busy;
        read_cycle_o = st.read_cycle;
        setup_o = st.setup;
        config_o = st.cfg;
        mode_o = st.mode;
    end
endmodule

// ==== test/tws_slave_properties.sv ====
// concurrent checks on the two-wire slave ports
`timescale 1ns/1ps
module tws_slave_properties
    import tws_pkg::*;
(
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic scl_clk_i,
    input wire logic scl_i,
    input wire logic sda_i,
    input wire logic [7:0] read_data_i,
    input wire logic sda_o,
    input wire logic sda_oe_n_o,
    input wire logic scl_o,
    input wire logic scl_oe_n_o,
    input wire logic high_speed_o,
    input wire logic busy_o,
    input wire logic read_cycle_o,
    input wire logic [7:0] setup_o,
    input wire logic [7:0] config_o,
    input wire tws_mode_t mode_o
);
    // one domain only, so clock and reset are given once
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);
    a_reset_state: assert property (
        $past(sys_rst_i) |-> setup_o == TWS_SETUP_RESET && config_o == TWS_CONFIG_RESET && !high_speed_o && !busy_o)
        else $error("state after reset wrong");
    a_lines_released: assert property (
        !sda_o && !scl_o && scl_oe_n_o && (busy_o || sda_oe_n_o))
        else $error("line driven while idle");
    a_drive_scl_low: assert property (
        $changed(sda_oe_n_o) |-> !scl_i && !$past(scl_i))
        else $error("sda drive moved while scl high");
    a_start_opens: assert property (
        $fell(sda_i) && scl_i && $past(scl_i) |-> ##[1:8] busy_o)
        else $error("start not seen");
    a_stop_closes: assert property (
        $rose(sda_i) && scl_i && $past(scl_i) |-> ##[1:8] (!busy_o && !high_speed_o))
        else $error("stop not seen");
    a_config_restore: assert property (
        $changed(setup_o) && !setup_o[TWS_RST_BIT] |-> ##[0:2] config_o == TWS_CONFIG_RESET)
        else $error("config not restored");
    a_single_unipolar: assert property (
        config_o[TWS_SGL_BIT] && $past(config_o[TWS_SGL_BIT]) |-> !mode_o.differential && !mode_o.bipolar_coding)
        else $error("single-ended coding wrong");
    a_diff_coding: assert property (
        !config_o[TWS_SGL_BIT] && $stable(config_o) && $stable(setup_o) |-> mode_o.differential
        && mode_o.bipolar_coding == setup_o[2] && mode_o.clamp_negative == !setup_o[2])
        else $error("differential coding wrong");
    a_field_decode: assert property (
        $stable(setup_o) && $stable(config_o) |-> mode_o.external_conv_clock == setup_o[3]
        && mode_o.reference_select == setup_o[6:4] && mode_o.channel_select == config_o[4:1])
        else $error("mode fields wrong");
    a_read_keeps: assert property (
        read_cycle_o |-> $stable(setup_o) && $stable(config_o))
        else $error("register written in read");
endmodule

// ==== test/tws_master_model.sv ====
// behavioural two-wire bus master: drives scl, pulls sda
`timescale 1ns/1ps
module tws_master_model #(
    parameter int H = 400 // half scl period in ns; slow so the synced sampler keeps up
)
(
    output logic scl_o,
    output logic sda_pull_o,
    input wire logic sda_i
);
    // bus idles released, scl stands still between frames
    initial
    begin
        scl_o = 1'b1;
        sda_pull_o = 1'b0;
    end
    // start, or repeated start when scl is low
    task bus_start;
        if (!scl_o)
        begin
            sda_pull_o = 1'b0;
            #(H) scl_o = 1'b1;
        end
        #(H) sda_pull_o = 1'b1;
        #(H) scl_o = 1'b0;
    endtask
    // stop: sda rises while scl high
    task bus_stop;
        #(H/2) sda_pull_o = 1'b1;
        #(H/2) scl_o = 1'b1;
        #(H) sda_pull_o = 1'b0;
        #(H);
    endtask
    // eight bits msb first, ninth bit carries mack; sda moves only with scl low
    task xfer(input logic [7:0] d, input logic mack, output logic [7:0] rd, output logic ack);
        logic b;
        for (int i = 0; i < 9; i++)
        begin
            b = (i < 8) ? d[7 - i] : mack;
            #(H/2) sda_pull_o = !b;
            #(H/2) scl_o = 1'b1;
            #(H/2);
            if (i < 8)
                rd[7 - i] = sda_i;
            else
                ack = !sda_i;
            #(H/2) scl_o = 1'b0;
        end
    endtask
endmodule

// ==== test/tws_slave_tb_top.sv ====
// testbench top for the two-wire slave front end
`timescale 1ns/1ps
module tws_slave_tb_top;
    import tws_pkg::*;
    logic clk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic [7:0] read_data_i = 8'h00;
    logic scl, pull, sda, sda_o, sda_oe_n_o, scl_o, scl_oe_n_o, high_speed_o, busy_o, read_cycle_o, ack;
    logic [7:0] setup_o, config_o, rd;
    tws_mode_t mode_o;
    int num_errors = 0;
    int n_compared = 0;
    // 25 mhz system clock
    always #20 clk_i = ~clk_i;
    // open-drain sda with pull-up
    assign sda = (pull || (!sda_oe_n_o && !sda_o)) ? 1'b0 : 1'b1;
    tws_master_model m (.scl_o(scl), .sda_pull_o(pull), .sda_i(sda));
    tws_slave dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .scl_clk_i(scl), .scl_i(scl), .sda_i(sda),
        .read_data_i(read_data_i), .sda_o(sda_o), .sda_oe_n_o(sda_oe_n_o), .scl_o(scl_o),
        .scl_oe_n_o(scl_oe_n_o), .high_speed_o(high_speed_o), .busy_o(busy_o), .read_cycle_o(read_cycle_o),
        .setup_o(setup_o), .config_o(config_o), .mode_o(mode_o));
    // compare and count
    task check(input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task test_done;
        if (num_errors == 0 && n_compared > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // one written byte and the slave's answer
    task send(input logic [7:0] d, input logic exp_ack);
        m.xfer(d, 1'b1, rd, ack);
        check(ack, exp_ack);
    endtask
    task t_reset;
        check(setup_o, TWS_SETUP_RESET);
        check(config_o, TWS_CONFIG_RESET);
        check(high_speed_o, 1'b0);
        check(mode_o.external_conv_clock, 1'b0);
    endtask
    task t_write;
        m.bus_start();
        send(8'hc8, 1'b1);
        send(8'h8a, 1'b1);
        send(8'h30, 1'b1);
        m.bus_stop();
        check(setup_o, 8'h8a);
        check(config_o, 8'h30);
        check(mode_o.scan_select, 2'h1);
        check(mode_o.channel_select, 4'h8);
        check(mode_o.external_conv_clock, 1'b1);
        check(busy_o, 1'b0);
    endtask
    // config then setup twice, then setup then config, repeated starts between cycles
    task t_order;
        m.bus_start();
        send(8'hc8, 1'b1);
        send(8'h00, 1'b1);
        send(8'h86, 1'b1);
        check(mode_o.differential, 1'b1);
        check(mode_o.bipolar_coding, 1'b1);
        m.bus_start();
        check(busy_o, 1'b1);
        send(8'hc8, 1'b1);
        send(8'h03, 1'b1);
        check(config_o, 8'h03);
        check(mode_o.bipolar_coding, 1'b0);
        send(8'h84, 1'b1);
        check(config_o, TWS_CONFIG_RESET);
        check(setup_o, 8'h84);
        m.bus_start();
        send(8'hc8, 1'b1);
        send(8'h82, 1'b1);
        send(8'h00, 1'b1);
        m.bus_stop();
        check(mode_o.clamp_negative, 1'b1);
        check(mode_o.bipolar_coding, 1'b0);
    endtask
    // other variant's address is ignored
    task t_wrong;
        m.bus_start();
        send(8'hca, 1'b0);
        send(8'h80, 1'b0);
        m.bus_stop();
        check(setup_o, 8'h82);
    endtask
    task t_read;
        @(posedge clk_i);
        #1 read_data_i = 8'h5a;
        m.bus_start();
        send(8'hc9, 1'b1);
        check(read_cycle_o, 1'b1);
        m.xfer(8'hff, 1'b1, rd, ack);
        check(rd, 8'h5a);
        repeat (6) @(posedge clk_i);
        #1;
        check(sda_oe_n_o, 1'b1);
        m.bus_stop();
    endtask
    // master code, repeated start, stop back to fast mode
    task t_hs;
        m.bus_start();
        send(8'h0d, 1'b0);
        repeat (6) @(posedge clk_i);
        #1;
        check(high_speed_o, 1'b1);
        m.bus_start();
        send(8'hc8, 1'b1);
        send(8'h8a, 1'b1);
        check(high_speed_o, 1'b1);
        m.bus_stop();
        check(high_speed_o, 1'b0);
    endtask
    // main sequence after a two-cycle reset
    initial
    begin
        repeat (2) @(posedge clk_i);
        #1 sys_rst_i = 1'b0;
        repeat (3) @(posedge clk_i);
        #1;
        t_reset();
        t_write();
        t_order();
        t_wrong();
        t_read();
        t_hs();
        test_done();
    end
    // watchdog well beyond the expected run of about 150 us
    initial
    begin
        #2000000;
        num_errors++;
        test_done();
    end
endmodule
bind tws_slave tws_slave_properties u_props (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .scl_clk_i(scl_clk_i),
    .scl_i(scl_i), .sda_i(sda_i), .read_data_i(read_data_i), .sda_o(sda_o), .sda_oe_n_o(sda_oe_n_o),
    .scl_o(scl_o), .scl_oe_n_o(scl_oe_n_o), .high_speed_o(high_speed_o), .busy_o(busy_o),
    .read_cycle_o(read_cycle_o), .setup_o(setup_o), .config_o(config_o), .mode_o(mode_o));
